// [common/negate_file_pkg.sv]
// package: constants for the negate-file execution unit
package negate_file_pkg;
	// ---------------------------------------------------------------
	// instruction encoding
	// ---------------------------------------------------------------
	localparam logic [6:0]  NEG_OPCODE      = 7'h36;  // 0110_110 in bits 15:9
	localparam int          OPC_MSB         = 15;
	localparam int          OPC_LSB         = 9;
	localparam int          ASEL_BIT        = 8;
	localparam int          FADDR_MSB       = 7;
	// ---------------------------------------------------------------
	// addressing
	// ---------------------------------------------------------------
	localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;  // 95: top of indexed window
	localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;  // first field of the upper access half
	localparam logic [5:0]  ACCESS_HI_BANK  = 6'h3f;  // bank holding upper access half
	localparam logic [7:0]  DATA_RESET      = 8'h00;
	localparam logic [13:0] ADDR_RESET      = 14'h0000;
	// ---------------------------------------------------------------
	// status flag positions
	// ---------------------------------------------------------------
	localparam int          FLAG_C          = 0;
	localparam int          FLAG_DC         = 1;
	localparam int          FLAG_Z          = 2;
	localparam int          FLAG_OV         = 3;
	localparam int          FLAG_N          = 4;
	localparam logic [4:0]  FLAGS_RESET     = 5'h00;
	// four-phase instruction cycle, one-hot
	typedef enum logic [3:0] {
		PH_DECODE  = 4'h1,
		PH_READ    = 4'h2,
		PH_PROCESS = 4'h4,
		PH_WRITE   = 4'h8
	} phase_t;
endpackage

// [rtl/negate_file_unit.sv]
// negate-file instruction execution unit: read, negate, flag, write back
`timescale 1ns/1ps
// Function
// RULE1 - negation is invert-plus-one of the operand, and N, OV, C, DC, Z follow the result.
// RULE2 - the result goes back to the same location read, picked by the 8-bit file field.
// RULE3 - access-select 0 resolves the file field in the access bank, bank select unused.
// RULE4 - access-select 1 joins the bank select register to the field to pick the bank.
// RULE5 - extended set on, access-select 0 and field at most 95 means indexed literal offset.
// RULE6 - one word, one cycle: decode in Q1, read in Q2, compute in Q3, write in Q4.
module negate_file_unit
	import negate_file_pkg::*;
#(
	parameter int ADDR_W = 14
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              instr_valid,
	input  wire logic [15:0]       instr_word,
	input  wire logic              ext_set_en,
	input  wire logic [5:0]        bank_select_register,
	input  wire logic [ADDR_W-1:0] index_base,
	input  wire logic [7:0]        mem_rdata,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic      [7:0]        mem_wdata,
	output logic      [4:0]        status_flags,
	output logic                   flags_wr,
	output logic                   busy,
	output logic                   done
);
	// ---------------------------------------------------------------
	// usage notes
	// ---------------------------------------------------------------
	// between instructions the sequencer rests in decode, so the four
	// phases run only while a negate word is in flight
	// words offered while busy are not looked at; a negate word still
	// valid in the decode after the write starts the next instruction
	// bank select, index base and the extended-set enable are sampled at
	// decode only, so they may change freely while busy
	// the memory must answer within the read phase: there is no stall
	// input, trading wait-state support for a fixed four-phase cycle
	// the indexed sum wraps at the address width, as a pointer would
	// status flags hold until the next negate; flags_wr marks the load

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// sequencer and datapath state
	phase_t            phase_reg, phase_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0]        opnd_reg, res_reg;
	logic [4:0]        flags_reg, flags_next;
	logic              active_reg;

	// instruction fields, used only while the phase is decode
	wire logic       is_neg   = instr_valid && instr_word[OPC_MSB:OPC_LSB] == NEG_OPCODE;
	wire logic       asel     = instr_word[ASEL_BIT];
	wire logic [7:0] ffield   = instr_word[FADDR_MSB:0];
	// indexed mode only when access bank would otherwise be chosen
	wire logic       use_idx  = ext_set_en && !asel && ffield <= INDEXED_LIMIT; // RULE5
	wire logic [ADDR_W-1:0] idx_addr  = index_base + ADDR_W'(ffield);          // RULE5
	wire logic [ADDR_W-1:0] bank_addr = ADDR_W'({bank_select_register, ffield}); // RULE4
	// access bank: low part from bank 0, high part from the top bank
	wire logic [ADDR_W-1:0] acc_addr  = (ffield < ACCESS_SPLIT) ? ADDR_W'(ffield)
		: ADDR_W'({ACCESS_HI_BANK, ffield});                                    // RULE3
	assign addr_next = use_idx ? idx_addr : (asel ? bank_addr : acc_addr);     // RULE2

	// ---------------------------------------------------------------
	// arithmetic: 0 - f, same as ~f + 1
	// ---------------------------------------------------------------
	wire logic [8:0] sum    = {1'b0, ~opnd_reg} + 9'h001;                       // RULE1
	wire logic [4:0] lo_sum = {1'b0, ~opnd_reg[3:0]} + 5'h01;
	wire logic [7:0] neg    = sum[7:0];
	always_comb begin
		flags_next          = FLAGS_RESET;
		flags_next[FLAG_C]  = sum[8];                                       // RULE1
		flags_next[FLAG_DC] = lo_sum[4];                                    // RULE1
		flags_next[FLAG_Z]  = neg == 8'h00;                                 // RULE1
		flags_next[FLAG_N]  = neg[7];                                       // RULE1
		flags_next[FLAG_OV] = ~opnd_reg[7] & neg[7] ? 1'b0 : (opnd_reg == 8'h80); // RULE1
	end

	// ---------------------------------------------------------------
	// phase sequencer
	// ---------------------------------------------------------------
	// phases only advance once an instruction is in flight
	always_comb begin
		unique case (phase_reg)
			PH_DECODE:  phase_next = (is_neg || active_reg) ? PH_READ : PH_DECODE;
			PH_READ:    phase_next = PH_PROCESS;
			PH_PROCESS: phase_next = PH_WRITE;
			PH_WRITE:   phase_next = PH_DECODE;
			default:    phase_next = PH_DECODE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_reg  <= PH_DECODE;
			active_reg <= 1'b0;
		end else begin
			phase_reg  <= phase_next;                                       // RULE6
			if (phase_reg == PH_DECODE)
				active_reg <= is_neg;
			else if (phase_reg == PH_WRITE)
				active_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// datapath registers
	// ---------------------------------------------------------------
	// address latched at decode so the write lands where the read did
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_reg  <= ADDR_W'(ADDR_RESET);
			opnd_reg  <= DATA_RESET;
			res_reg   <= DATA_RESET;
			flags_reg <= FLAGS_RESET;
		end else begin
			if (phase_reg == PH_DECODE && is_neg)
				addr_reg <= addr_next;                                      // RULE2
			if (phase_reg == PH_READ && active_reg)
				opnd_reg <= mem_rdata;                                      // RULE6
			if (phase_reg == PH_PROCESS && active_reg) begin
				res_reg   <= neg;                                           // RULE1
				flags_reg <= flags_next;                                    // RULE1
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign mem_addr     = addr_reg;
	assign mem_wdata    = res_reg;
	assign status_flags = flags_reg;
	assign mem_rd       = active_reg && phase_reg == PH_READ;               // RULE6
	assign mem_wr       = active_reg && phase_reg == PH_WRITE;              // RULE6
	assign flags_wr     = mem_wr;
	assign done         = mem_wr;
	assign busy         = active_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// a negate word taken in decode, then the three phases that follow it
	sequence s_decoded;
		phase_reg == PH_DECODE && is_neg;
	endsequence
	sequence s_rest;
		##1 mem_rd ##1 !mem_rd && !mem_wr ##1 mem_wr;
	endsequence

	// read in Q2, nothing on the port in Q3, write in Q4, no gaps
	chk_phase_order: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
		s_decoded |-> s_rest) else $error("phase order broken");
	// result is the two's complement of the byte that was read
	chk_neg_value: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		mem_wr |-> mem_wdata == 8'(~$past(opnd_reg) + 8'h01)) else $error("bad negation");
	// zero flag follows the byte being written
	chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		flags_wr |-> status_flags[FLAG_Z] == (mem_wdata == 8'h00)) else $error("bad zero flag");
	// carry out of ~f + 1 only when f was zero, so it tracks a zero result
	chk_carry_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		flags_wr |-> status_flags[FLAG_C] == (mem_wdata == 8'h00)) else $error("bad carry flag");
	// write two cycles after the read, at the very address the read used
	chk_same_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE2
		mem_rd |-> ##2 (mem_wr && mem_addr == $past(mem_addr, 2)))
		else $error("write address moved");
	// low access half maps straight onto bank 0
	chk_access_bank: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE3
		s_decoded ##0 (!asel && !use_idx && ffield < ACCESS_SPLIT)
		|=> mem_addr == ADDR_W'($past(ffield))) else $error("access bank wrong");
	// banked access: bank select on top, file field below, whatever the
	// extended-set enable says
	chk_banked_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE4
		s_decoded ##0 asel |=> mem_addr == ADDR_W'({$past(bank_select_register),
		$past(ffield)})) else $error("banked address wrong");
	// indexed window wins over the access bank for small fields
	chk_indexed_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE5
		s_decoded ##0 (ext_set_en && !asel && ffield <= INDEXED_LIMIT)
		|=> mem_addr == ADDR_W'($past(index_base) + ADDR_W'($past(ffield))))
		else $error("indexed address wrong");
	// upper access half lands in the top bank, not in bank 0
	chk_access_high: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE3
		s_decoded ##0 (!asel && !use_idx && ffield >= ACCESS_SPLIT)
		|=> mem_addr == ADDR_W'({ACCESS_HI_BANK, $past(ffield)}))
		else $error("upper access half wrong");

	// ---------------------------------------------------------------
	// checks: flags against the operand held through the cycle
	// ---------------------------------------------------------------
	// the operand register stands from the read edge to the next read,
	// so it can serve as the reference while the flags are written
	// digit carry only when the low nibble of the operand was zero
	chk_dc_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		flags_wr |-> status_flags[FLAG_DC] == (opnd_reg[3:0] == 4'h0))
		else $error("bad digit carry flag");
	// only the most negative byte has no positive twin
	chk_ov_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		flags_wr |-> status_flags[FLAG_OV] == (opnd_reg == 8'h80))
		else $error("bad overflow flag");
	chk_neg_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
		flags_wr |-> status_flags[FLAG_N] == mem_wdata[7])
		else $error("bad negative flag");

	// ---------------------------------------------------------------
	// checks: timing of one instruction cycle
	// ---------------------------------------------------------------
	// three busy cycles after decode, then idle again for the next word
	sequence s_busy_run;
		busy [*3] ##1 !busy;
	endsequence
	chk_busy_span: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
		s_decoded |=> s_busy_run) else $error("busy span wrong");
	// the byte on the read port in Q2 is the one that gets negated
	chk_read_capture: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
		mem_rd |=> opnd_reg == $past(mem_rdata)) else $error("operand not captured");
	// a word arriving mid-instruction must not move the target location
	chk_addr_held: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE2
		busy |=> $stable(mem_addr)) else $error("address moved while busy");
	// one write per instruction, and the unit is free right after it
	chk_write_single: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
		mem_wr |=> !mem_wr && !busy) else $error("write strobe repeated");
endmodule

// [tb/data_mem_model.sv]
// data memory model standing beyond the negate unit's memory port
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic        clk_sys,
	input  wire logic [13:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:16383];
	logic [7:0] last_q = 8'h00;
	// data only with the strobe; inverted stale byte otherwise, so a late sample never matches
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
	// write-back lands at whatever address the unit presents; plain always
	// because the bench preloads bytes into the same array
	always @(posedge clk_sys) begin
		if (mem_rd) last_q <= mem[mem_addr];
		if (mem_wr) mem[mem_addr] <= mem_wdata;
	end
endmodule

// [tb/tb.sv]
// self-checking bench for the negate-file unit against a reference model
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
	import negate_file_pkg::*;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic        ext_set_en = 1'b0;
	logic [5:0]  bank_select_register = 6'h00;
	logic [13:0] index_base = 14'h0000;
	logic [7:0]  mem_rdata, mem_wdata;
	logic [13:0] mem_addr;
	logic [4:0]  status_flags;
	logic        mem_rd, mem_wr, flags_wr, busy, done;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          seed = 32'h1bf9;
	int          exp_q[$];
	negate_file_unit i_dut (.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
		.instr_word(instr_word), .ext_set_en(ext_set_en), .index_base(index_base),
		.bank_select_register(bank_select_register), .mem_rdata(mem_rdata),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.status_flags(status_flags), .flags_wr(flags_wr), .busy(busy), .done(done));
	data_mem_model i_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// 10 MHz clock
	initial forever #50 clk_sys = ~clk_sys;
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard: the whole run needs about 260 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			tally_and_finish;
		end
	end
	// ---------------------------------------------------------------
	// one instruction: reference address, result and flags
	// ---------------------------------------------------------------
	task run_one(input int i);
		logic [7:0]  f, v;
		logic        a, neg;
		logic [13:0] ea;
		int          vi, ri, fi;
		f = (i % 5 == 0) ? 8'h5f : (i % 5 == 1) ? 8'h60 : 8'($random(seed));
		v = (i % 7 == 0) ? 8'h80 : (i % 7 == 1) ? 8'h00 : 8'($random(seed));
		neg = (i % 6 != 5);
		a = 1'($random(seed));
		ext_set_en = 1'($random(seed));
		bank_select_register = 6'($random(seed));
		index_base = 14'($random(seed));
		ea = a ? {bank_select_register, f} : (ext_set_en && f <= INDEXED_LIMIT) ?
			index_base + 14'(f) : (f < ACCESS_SPLIT) ? {6'h00, f} : {ACCESS_HI_BANK, f};
		i_mem.mem[ea] = v;
		// reference in integers: 0 - v modulo 256, flags from their definitions
		vi = int'(v);
		ri = (256 - vi) % 256;
		fi = 0;
		if (ri >= 128) fi += 1 << FLAG_N;
		if (vi == 128) fi += 1 << FLAG_OV;
		if (ri == 0) fi += 1 << FLAG_Z;
		if (vi % 16 == 0) fi += 1 << FLAG_DC;
		if (vi == 0) fi += 1 << FLAG_C;
		if (neg) begin
			exp_q.push_back(ri);
			exp_q.push_back(fi);
		end
		// non-negate cases: a foreign opcode, or a negate word without valid
		instr_word = {(neg || i % 12 == 11) ? NEG_OPCODE : 7'h37, a, f};
		instr_valid = neg || (i % 12 == 5);
		@(negedge clk_sys);
		`CHK(mem_rd, neg)
		if (!neg) begin
			`CHK(busy, 1'b0)
			return;
		end
		// a fresh word while busy must be ignored
		instr_word = 16'($random(seed));
		`CHK(mem_addr, ea)
		@(negedge clk_sys);
		`CHK(mem_wr, 1'b0)
		@(negedge clk_sys);
		`CHK({done, flags_wr}, 2'b11)
		instr_valid = 1'b0;
		@(negedge clk_sys);
		ri = exp_q.pop_front();
		fi = exp_q.pop_front();
		`CHK(mem_wdata, 8'(ri))
		`CHK(status_flags, 5'(fi))
		`CHK(i_mem.mem[ea], 8'(ri))
		`CHK(busy, 1'b0)
	endtask
	// reset for six cycles, then a run of random and boundary instructions
	initial begin
		repeat (6) @(negedge clk_sys);
		nrst = 1'b1;
		for (int i = 0; i < 60; i++) run_one(i);
		// reset while an instruction is in flight: everything back to idle
		instr_word = {NEG_OPCODE, 1'b1, 8'h10};
		instr_valid = 1'b1;
		@(negedge clk_sys);
		`CHK(busy, 1'b1)
		nrst = 1'b0;
		instr_valid = 1'b0;
		@(negedge clk_sys);
		`CHK({busy, mem_rd, mem_wr, done, flags_wr}, 5'h00)
		`CHK({mem_addr, mem_wdata, status_flags}, 27'h0000000)
		nrst = 1'b1;
		for (int i = 0; i < 12; i++) run_one(i);
		tally_and_finish;
	end
endmodule
